// file: src/aio_pkg.sv
// Constants, offsets and layouts shared by the auxiliary line, command and alarm register bank.
package aio_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses (low byte at the even address)
  // ---------------------------------------------------------------
  localparam logic [6:0] X_ACCEL_OFFSET_NULL_ADDR    = 7'h10;
  localparam logic [6:0] Y_ACCEL_OFFSET_NULL_ADDR    = 7'h12;
  localparam logic [6:0] X_TILT_OFFSET_NULL_ADDR     = 7'h14;
  localparam logic [6:0] Y_TILT_OFFSET_NULL_ADDR     = 7'h16;
  localparam logic [6:0] ROTATION_OFFSET_NULL_ADDR   = 7'h18;
  localparam logic [6:0] ALARM_ONE_THRESHOLD_ADDR    = 7'h20;
  localparam logic [6:0] ALARM_TWO_THRESHOLD_ADDR    = 7'h22;
  localparam logic [6:0] ALARM_ONE_SAMPLE_COUNT_ADDR = 7'h24;
  localparam logic [6:0] ALARM_TWO_SAMPLE_COUNT_ADDR = 7'h26;
  localparam logic [6:0] ALARM_SETUP_ADDR            = 7'h28;
  localparam logic [6:0] AUX_CONVERTER_LEVEL_ADDR    = 7'h30;
  localparam logic [6:0] LINE_DIRECTION_DATA_ADDR    = 7'h32;
  localparam logic [6:0] GLOBAL_COMMAND_ADDR         = 7'h3e;

  // ---------------------------------------------------------------
  // Backed-up, level and line register indices, masks and reset values
  // ---------------------------------------------------------------
  localparam int NUM_KEPT      = 10;
  localparam int NUM_NULLS     = 5;
  localparam int IDX_THR_ONE   = 5;
  localparam int IDX_SMPL_ONE  = 7;
  localparam int IDX_SETUP     = 9;
  localparam logic [15:0] NULL_MASK      = 16'h3fff;
  localparam logic [15:0] THRESHOLD_MASK = 16'hbfff;
  localparam logic [15:0] SAMPLE_MASK    = 16'h00ff;
  localparam logic [15:0] SETUP_MASK     = 16'hff7f;
  localparam logic [15:0] KEPT_RESET     = 16'h0000;
  localparam logic [15:0] SAMPLE_RESET   = 16'h0001;
  localparam logic [15:0] LEVEL_MASK     = 16'h0fff;
  localparam logic [15:0] LEVEL_RESET    = 16'h0000;
  localparam logic [15:0] LINE_MASK      = 16'h0303;
  localparam logic [15:0] LINE_RESET     = 16'h0000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LINE_DIR_BIT    = 0;
  localparam int LINE_DATA_BIT   = 8;
  localparam int CMD_SW_RESET    = 7;
  localparam int CMD_STAT_CLEAR  = 4;
  localparam int CMD_BACKUP      = 3;
  localparam int CMD_LATCH       = 2;
  localparam int CMD_RESTORE     = 1;
  localparam int CMD_AUTONULL    = 0;
  localparam int THR_GT_BIT      = 15;
  localparam int SETUP_SRC_LSB   = 8;
  localparam int SETUP_RATE_BIT  = 5;
  localparam int SETUP_FILT_BIT  = 3;
  localparam int SETUP_IND_EN    = 2;
  localparam int SETUP_IND_POL   = 1;
  localparam int SETUP_IND_SEL   = 0;

  // ---------------------------------------------------------------
  // Alarm source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_DISABLED = 4'h0;
  localparam logic [3:0] SRC_X_TILT   = 4'h6;
  localparam logic [3:0] SRC_LAST     = 4'h8;
  localparam int         NUM_SOURCES  = 9;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ        = 125000;
  localparam int FLASH_TIME_MS  = 50;
  localparam int FLASH_CYCLES   = FLASH_TIME_MS * CLK_KHZ;

endpackage : aio_pkg

// file: src/aio_regs.sv
// Auxiliary line, converter level, global command, offset-null and alarm register bank.
`timescale 1ns/100ps

module aio_regs
  import aio_pkg::*;
#(
  parameter int FLASH_WAIT = FLASH_CYCLES
)
(
  input  wire logic                     ref_clk,         // Block clock
  input  wire logic                     sys_rst,         // Synchronous reset, active high
  input  wire logic [6:0]               regAddr,         // Register byte address
  input  wire logic [7:0]               wrByte,          // Byte to write
  input  wire logic                     wrStrobe,        // Byte write request
  input  wire logic                     rdStrobe,        // Word read request
  output logic      [15:0]              rdData,          // Read word
  input  wire logic                     statusRead,      // Status register was read
  input  wire logic [NUM_NULLS-1:0][13:0] resultData,    // Five sensor results
  input  wire logic [NUM_SOURCES-1:0][13:0] rawData,     // Unfiltered source data
  input  wire logic [NUM_SOURCES-1:0][13:0] filtData,    // Filtered source data
  input  wire logic                     sampleStrobe,    // New sample available
  input  wire logic                     flashFail,       // Store reports failure
  input  wire logic [1:0]               lineIn,          // Digital line levels
  output logic      [1:0]               lineOut,         // Digital line drive value
  output logic      [1:0]               lineOe,          // Digital line drive enable
  output logic      [11:0]              converterCode,   // Latched converter code
  output logic      [NUM_KEPT-1:0][15:0] keptRegs,       // Live kept registers
  output logic                          swResetPulse,    // Processor restart pulse
  output logic                          statusClearPulse,// Status clear pulse
  output logic                          flashBusy,       // Backup in progress
  output logic                          flashError,      // Backup failed flag
  output logic      [1:0]               alarmActive      // Alarm one/two flags
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (FLASH_WAIT < 1 || FLASH_WAIT > 8388607)
  begin : gBadWait
    $error("FLASH_WAIT out of range");
  end

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] keptIndex(input logic [6:0] a);
    logic [5:0] w;
    w = a[6:1];
    if (w == X_ACCEL_OFFSET_NULL_ADDR[6:1]) keptIndex = 5'h10;
    else if (w == Y_ACCEL_OFFSET_NULL_ADDR[6:1]) keptIndex = 5'h11;
    else if (w == X_TILT_OFFSET_NULL_ADDR[6:1]) keptIndex = 5'h12;
    else if (w == Y_TILT_OFFSET_NULL_ADDR[6:1]) keptIndex = 5'h13;
    else if (w == ROTATION_OFFSET_NULL_ADDR[6:1]) keptIndex = 5'h14;
    else if (w == ALARM_ONE_THRESHOLD_ADDR[6:1]) keptIndex = 5'h15;
    else if (w == ALARM_TWO_THRESHOLD_ADDR[6:1]) keptIndex = 5'h16;
    else if (w == ALARM_ONE_SAMPLE_COUNT_ADDR[6:1]) keptIndex = 5'h17;
    else if (w == ALARM_TWO_SAMPLE_COUNT_ADDR[6:1]) keptIndex = 5'h18;
    else if (w == ALARM_SETUP_ADDR[6:1]) keptIndex = 5'h19;
    else keptIndex = 5'h00;
  endfunction : keptIndex

  function automatic logic [15:0] keptMask(input int i);
    if (i < NUM_NULLS) keptMask = NULL_MASK;
    else if (i < IDX_SMPL_ONE) keptMask = THRESHOLD_MASK;
    else if (i < IDX_SETUP) keptMask = SAMPLE_MASK;
    else keptMask = SETUP_MASK;
  endfunction : keptMask

  function automatic logic [15:0] keptReset(input int i);
    if (i >= IDX_SMPL_ONE && i < IDX_SETUP) keptReset = SAMPLE_RESET;
    else keptReset = KEPT_RESET;
  endfunction : keptReset

  function automatic logic [15:0] byteWrite(input logic [15:0] old, input logic hi,
                                            input logic [7:0] b);
    byteWrite = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : byteWrite

  // ---------------------------------------------------------------
  // Register and command state
  // ---------------------------------------------------------------
  logic [NUM_KEPT-1:0][15:0] kept, next_kept, nvStore, next_nvStore;
  logic [15:0] level, next_level, lineReg, next_lineReg, next_rdData;
  logic [11:0] next_converterCode;
  logic [22:0] flashCount, next_flashCount;
  logic        next_flashBusy, next_flashError, next_swResetPulse, next_statusClearPulse;
  logic [1:0]  next_lineOut, next_lineOe;
  logic [4:0]  wIdx;
  logic        cmdWrite, indLevel;
  logic [7:0]  cmd;

  assign wIdx = keptIndex(regAddr);
  assign cmdWrite = wrStrobe && !flashBusy && regAddr == GLOBAL_COMMAND_ADDR;
  assign cmd = cmdWrite ? wrByte : 8'h00;

  always_comb
  begin
    next_kept = kept;
    next_nvStore = nvStore;
    next_level = level;
    next_lineReg = lineReg;
    next_converterCode = converterCode;
    next_flashCount = flashCount;
    next_flashBusy = flashBusy;
    next_flashError = flashError;
    next_swResetPulse = cmd[CMD_SW_RESET];
    next_statusClearPulse = cmd[CMD_STAT_CLEAR];
    next_rdData = rdData;
    indLevel = 1'b0;
    if (wrStrobe && !flashBusy)
    begin
      if (wIdx[4])
      begin
        next_kept[wIdx[3:0]] = byteWrite(kept[wIdx[3:0]], regAddr[0], wrByte)
                               & keptMask(int'(wIdx[3:0]));
      end
      else if (regAddr[6:1] == AUX_CONVERTER_LEVEL_ADDR[6:1])
      begin
        next_level = byteWrite(level, regAddr[0], wrByte) & LEVEL_MASK;
      end
      else if (regAddr[6:1] == LINE_DIRECTION_DATA_ADDR[6:1])
      begin
        next_lineReg = byteWrite(lineReg, regAddr[0], wrByte) & LINE_MASK;
      end
    end
    if (cmd[CMD_LATCH])
    begin
      next_converterCode = level[11:0];
    end
    if (cmd[CMD_RESTORE])
    begin
      for (int i = 0; i < NUM_NULLS; i++)
      begin
        next_kept[i] = KEPT_RESET;
      end
    end
    if (cmd[CMD_AUTONULL])
    begin
      for (int i = 0; i < NUM_NULLS; i++)
      begin
        next_kept[i] = {2'b00, 14'(-resultData[i])};
      end
    end
    if ((cmd[CMD_BACKUP] || cmd[CMD_AUTONULL]) && !flashError)
    begin
      next_flashBusy = 1'b1;
      next_flashCount = 23'(FLASH_WAIT - 1);
    end
    else if (flashBusy)
    begin
      if (flashCount == 23'h000000)
      begin
        next_flashBusy = 1'b0;
        if (flashFail)
        begin
          next_flashError = 1'b1;
        end
        else
        begin
          next_nvStore = kept;
        end
      end
      else
      begin
        next_flashCount = flashCount - 23'h000001;
      end
    end
    if ((statusRead || cmd[CMD_STAT_CLEAR]) && !(flashBusy && flashCount == 23'h000000
        && flashFail))
    begin
      next_flashError = 1'b0;
    end
    if (cmd[CMD_SW_RESET])
    begin
      next_kept = nvStore;
      next_level = LEVEL_RESET;
      next_converterCode = LEVEL_RESET[11:0];
      next_lineReg = LINE_RESET;
    end
    if (rdStrobe)
    begin
      if (wIdx[4]) next_rdData = kept[wIdx[3:0]];
      else if (regAddr[6:1] == AUX_CONVERTER_LEVEL_ADDR[6:1]) next_rdData = level;
      else if (regAddr[6:1] == LINE_DIRECTION_DATA_ADDR[6:1])
        next_rdData = {6'h00, lineIn, 6'h00, lineReg[1:0]};
      else next_rdData = 16'h0000;
    end
    // Indicator takes its line over from the general-purpose setting.
    indLevel = kept[IDX_SETUP][SETUP_IND_POL] ? (|alarmActive) : !(|alarmActive);
    for (int k = 0; k < 2; k++)
    begin
      if (kept[IDX_SETUP][SETUP_IND_EN] && int'(kept[IDX_SETUP][SETUP_IND_SEL]) == k)
      begin
        next_lineOe[k] = 1'b1;
        next_lineOut[k] = indLevel;
      end
      else
      begin
        next_lineOe[k] = lineReg[LINE_DIR_BIT + k];
        next_lineOut[k] = lineReg[LINE_DIR_BIT + k] && lineReg[LINE_DATA_BIT + k];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_KEPT; i++)
      begin
        kept[i] <= keptReset(i);
        nvStore[i] <= keptReset(i);
      end
      level <= LEVEL_RESET;
      lineReg <= LINE_RESET;
      converterCode <= LEVEL_RESET[11:0];
      flashCount <= 23'h000000;
      flashBusy <= 1'b0;
      flashError <= 1'b0;
      swResetPulse <= 1'b0;
      statusClearPulse <= 1'b0;
      rdData <= 16'h0000;
      lineOut <= 2'b00;
      lineOe <= 2'b00;
    end
    else
    begin
      kept <= next_kept;
      nvStore <= next_nvStore;
      level <= next_level;
      lineReg <= next_lineReg;
      converterCode <= next_converterCode;
      flashCount <= next_flashCount;
      flashBusy <= next_flashBusy;
      flashError <= next_flashError;
      swResetPulse <= next_swResetPulse;
      statusClearPulse <= next_statusClearPulse;
      rdData <= next_rdData;
      lineOut <= next_lineOut;
      lineOe <= next_lineOe;
    end
  end

  assign keptRegs = kept;

  // ---------------------------------------------------------------
  // Alarm channels
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : gAlarm
    logic [3:0]  src;
    logic        rateOn, useFilt;
    logic [15:0] thr;
    logic [8:0]  needN;
    logic signed [13:0] val, thrVal, prevVal, next_prevVal;
    logic signed [23:0] diffSum, next_diffSum, limit;
    logic [7:0]  sampCnt, next_sampCnt;
    logic        havePrev, next_havePrev, next_active, hit;

    assign src = kept[IDX_SETUP][SETUP_SRC_LSB + 4*ch +: 4];
    assign rateOn = kept[IDX_SETUP][SETUP_RATE_BIT + ch];
    assign useFilt = kept[IDX_SETUP][SETUP_FILT_BIT + ch] || src >= SRC_X_TILT;
    assign thr = kept[IDX_THR_ONE + ch];
    assign thrVal = signed'(thr[13:0]);
    assign needN = (kept[IDX_SMPL_ONE + ch][7:0] == 8'h00) ? 9'h001
                   : {1'b0, kept[IDX_SMPL_ONE + ch][7:0]};
    assign val = (src > SRC_LAST || src == SRC_DISABLED) ? 14'sh0000
                 : signed'(useFilt ? filtData[src] : rawData[src]);
    assign limit = 24'(thrVal * signed'({1'b0, needN}));

    always_comb
    begin
      next_prevVal = prevVal;
      next_diffSum = diffSum;
      next_sampCnt = sampCnt;
      next_havePrev = havePrev;
      hit = 1'b0;
      if (src == SRC_DISABLED || src > SRC_LAST)
      begin
        next_havePrev = 1'b0;
        next_diffSum = 24'sh000000;
        next_sampCnt = 8'h00;
      end
      else if (sampleStrobe)
      begin
        if (!rateOn)
        begin
          hit = thr[THR_GT_BIT] ? (val > thrVal) : (val < thrVal);
        end
        else if (havePrev)
        begin
          next_diffSum = diffSum + 24'(val - prevVal);
          if ({1'b0, sampCnt} + 9'h001 >= needN)
          begin
            // Sum against threshold times count equals mean against threshold.
            hit = thr[THR_GT_BIT] ? (next_diffSum > limit) : (next_diffSum < limit);
            next_diffSum = 24'sh000000;
            next_sampCnt = 8'h00;
          end
          else
          begin
            next_sampCnt = sampCnt + 8'h01;
          end
        end
        next_prevVal = val;
        next_havePrev = 1'b1;
      end
      next_active = alarmActive[ch];
      if (cmd[CMD_STAT_CLEAR])
      begin
        next_active = 1'b0;
      end
      if (hit)
      begin
        next_active = 1'b1;
      end
    end

    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        prevVal <= 14'sh0000;
        diffSum <= 24'sh000000;
        sampCnt <= 8'h00;
        havePrev <= 1'b0;
        alarmActive[ch] <= 1'b0;
      end
      else
      begin
        prevVal <= next_prevVal;
        diffSum <= next_diffSum;
        sampCnt <= next_sampCnt;
        havePrev <= next_havePrev;
        alarmActive[ch] <= next_active;
      end
    end
  end

endmodule : aio_regs

// file: tb/aio_regs_monitor.sv
// Concurrent checks on the ports of the auxiliary line, command and alarm register bank.
`timescale 1ns/100ps
module aio_regs_monitor
  import aio_pkg::*;
#(
  parameter int FLASH_WAIT = 20
)
(
  input wire logic                      ref_clk,          // Block clock
  input wire logic                      sys_rst,          // Synchronous reset
  input wire logic [6:0]                regAddr,          // Register byte address
  input wire logic [7:0]                wrByte,           // Byte to write
  input wire logic                      wrStrobe,         // Byte write request
  input wire logic                      statusRead,       // Status register was read
  input wire logic                      sampleStrobe,     // New sample available
  input wire logic [11:0]               converterCode,    // Latched converter code
  input wire logic [NUM_KEPT-1:0][15:0] keptRegs,         // Live kept registers
  input wire logic                      swResetPulse,     // Processor restart pulse
  input wire logic                      statusClearPulse, // Status clear pulse
  input wire logic                      flashBusy,        // Backup in progress
  input wire logic                      flashError,       // Backup failed flag
  input wire logic [1:0]                alarmActive       // Alarm flags
);
  logic [31:0] busyCount;
  logic [31:0] next_busyCount;
  logic        cmdWr;
  logic [3:0]  srcOne;

  // Counts busy cycles so the backup span can be measured.
  assign cmdWr  = wrStrobe && !flashBusy && (regAddr == GLOBAL_COMMAND_ADDR);
  assign srcOne = keptRegs[IDX_SETUP][11:8];
  always_comb next_busyCount = flashBusy ? busyCount + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) busyCount <= sys_rst ? 32'h0 : next_busyCount;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_LATCH_ONLY: assert property (!$stable(converterCode) |-> $past(sys_rst) ||
    $past(cmdWr && (wrByte[CMD_LATCH] || wrByte[CMD_SW_RESET])))
    else $error("converter code changed without latch command");
  AST_SW_RESET: assert property (cmdWr && wrByte[CMD_SW_RESET] |=> swResetPulse)
    else $error("software reset gave no restart pulse");
  AST_STAT_CLEAR: assert property (cmdWr && wrByte[CMD_STAT_CLEAR] |=> statusClearPulse)
    else $error("status clear gave no pulse");
  AST_BACKUP_START: assert property (cmdWr && !flashError &&
    !wrByte[CMD_SW_RESET] && (wrByte[CMD_BACKUP] || wrByte[CMD_AUTONULL]) |=> flashBusy)
    else $error("backup did not start");
  AST_BUSY_SPAN: assert property ($fell(flashBusy) |-> busyCount == FLASH_WAIT)
    else $error("backup span has wrong length");
  AST_ERR_BLOCKS: assert property (cmdWr && wrByte[CMD_BACKUP] && flashError &&
    !statusRead |=> !flashBusy)
    else $error("backup started with error flag set");
  AST_ERR_READ_CLEAR: assert property (flashError && statusRead && !flashBusy |=>
    !flashError)
    else $error("status read did not clear error flag");
  AST_ALARM_SOURCE: assert property ($rose(alarmActive[0]) |-> $past(sampleStrobe) &&
    $past(srcOne) != SRC_DISABLED && $past(srcOne) <= SRC_LAST)
    else $error("alarm one set without enabled source");
  AST_SAMPLE_RESET: assert property ($fell(sys_rst) |->
    keptRegs[IDX_SMPL_ONE] == SAMPLE_RESET && keptRegs[IDX_SMPL_ONE + 1] == SAMPLE_RESET)
    else $error("sample count reset value wrong");

  COV_BACKUP: cover property ($fell(flashBusy));
  COV_ALARM: cover property ($rose(alarmActive[0]));
  COV_ERROR: cover property ($rose(flashError));
endmodule : aio_regs_monitor

bind aio_regs aio_regs_monitor #(.FLASH_WAIT(FLASH_WAIT)) mon_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .wrByte(wrByte),
  .wrStrobe(wrStrobe), .statusRead(statusRead), .sampleStrobe(sampleStrobe),
  .converterCode(converterCode), .keptRegs(keptRegs), .swResetPulse(swResetPulse),
  .statusClearPulse(statusClearPulse), .flashBusy(flashBusy), .flashError(flashError),
  .alarmActive(alarmActive)
);

// file: tb/aio_far_side_model.sv
// Model of the outside circuit on the digital lines and of the nonvolatile store.
`timescale 1ns/100ps
module aio_far_side_model
(
  input  wire logic [1:0] lineOut,  // Device line drive value
  input  wire logic [1:0] lineOe,   // Device line drive enable
  input  wire logic [1:0] extLevel, // Level set by the outside circuit
  input  wire logic       failMode, // Store refuses backups
  output logic      [1:0] lineIn,   // Resolved line levels
  output logic            flashFail // Store failure report
);
  // A line the device does not drive shows the outside level.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      lineIn[i] = lineOe[i] ? lineOut[i] : extLevel[i];
  end
  assign flashFail = failMode;
endmodule : aio_far_side_model

// file: tb/aio_regs_tb_top.sv
// Self-checking testbench of the auxiliary line, command and alarm register bank.
`timescale 1ns/100ps
module aio_regs_tb_top
  import aio_pkg::*;
;
  logic                         ref_clk = 1'b0;
  logic                         sys_rst = 1'b1;
  logic [6:0]                   regAddr = 7'h00;
  logic [7:0]                   wrByte = 8'h00;
  logic                         wrStrobe = 1'b0;
  logic                         rdStrobe = 1'b0;
  logic                         statusRead = 1'b0;
  logic                         sampleStrobe = 1'b0;
  logic                         failMode = 1'b0;
  logic [1:0]                   extLevel = 2'b01;
  logic [NUM_NULLS-1:0][13:0]   resultData = '0;
  logic [NUM_SOURCES-1:0][13:0] rawData = '0;
  logic [NUM_SOURCES-1:0][13:0] filtData = '0;
  logic [15:0]                  rdData;
  logic                         flashFail;
  logic [1:0]                   lineIn, lineOut, lineOe, alarmActive;
  logic [11:0]                  converterCode;
  logic [NUM_KEPT-1:0][15:0]    keptRegs;
  logic                         swResetPulse, statusClearPulse, flashBusy, flashError;
  int                           failures = 0;
  int                           total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  aio_regs #(.FLASH_WAIT(20)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .wrByte(wrByte),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .statusRead(statusRead),
    .resultData(resultData), .rawData(rawData), .filtData(filtData),
    .sampleStrobe(sampleStrobe), .flashFail(flashFail), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .converterCode(converterCode), .keptRegs(keptRegs),
    .swResetPulse(swResetPulse), .statusClearPulse(statusClearPulse),
    .flashBusy(flashBusy), .flashError(flashError), .alarmActive(alarmActive));

  aio_far_side_model far_u (.lineOut(lineOut), .lineOe(lineOe), .extLevel(extLevel),
    .failMode(failMode), .lineIn(lineIn), .flashFail(flashFail));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  task automatic do_reset;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic wrb(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrByte <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask : wrb

  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    wrb(a, d[7:0]);
    wrb(a | 7'h01, d[15:8]);
  endtask : wr16

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    @(negedge ref_clk);
    check(rdData, exp);
  endtask : rd

  task automatic strobe(input logic [13:0] v);
    @(posedge ref_clk);
    rawData[2] <= v;
    sampleStrobe <= 1'b1;
    @(posedge ref_clk);
    sampleStrobe <= 1'b0;
    settle();
  endtask : strobe

  // Waits at most 100 cycles for the backup to finish; a timeout counts as a failure.
  task automatic wait_idle;
    int n;
    n = 0;
    while (flashBusy !== 1'b0 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 100)
      failures++;
  endtask : wait_idle

  function automatic logic [6:0] tab_addr(input int i);
    if (i < 5)
      return X_ACCEL_OFFSET_NULL_ADDR + 7'(2 * i);
    if (i < 10)
      return ALARM_ONE_THRESHOLD_ADDR + 7'(2 * (i - 5));
    return AUX_CONVERTER_LEVEL_ADDR;
  endfunction : tab_addr

  function automatic logic [15:0] tab_mask(input int i);
    if (i < 5)
      return NULL_MASK;
    if (i < 7)
      return THRESHOLD_MASK;
    if (i < 9)
      return SAMPLE_MASK;
    return (i == 9) ? SETUP_MASK : LEVEL_MASK;
  endfunction : tab_mask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    for (int i = 0; i < 11; i++)
      rd(tab_addr(i), (i == 7 || i == 8) ? SAMPLE_RESET : 16'h0000);
    rd(7'h3a, 16'h0000);
    for (int i = 0; i < 11; i++)
    begin
      wr16(tab_addr(i), 16'hffff);
      rd(tab_addr(i), tab_mask(i));
    end
    do_reset();
    wrb(AUX_CONVERTER_LEVEL_ADDR, 8'hbc);
    wrb(AUX_CONVERTER_LEVEL_ADDR + 7'h01, 8'h0a);
    settle();
    check({4'h0, converterCode}, 16'h0000);
    wrb(GLOBAL_COMMAND_ADDR, 8'h04);
    settle();
    check({4'h0, converterCode}, 16'h0abc);
    wr16(LINE_DIRECTION_DATA_ADDR, 16'h0302);
    settle();
    check({12'h000, lineOe, lineOut}, 16'h000a);
    rd(LINE_DIRECTION_DATA_ADDR, 16'h0302);
    wr16(ALARM_ONE_THRESHOLD_ADDR, 16'h0064);
    wr16(ALARM_SETUP_ADDR, 16'h0207);
    strobe(14'd200);
    check({14'h0, alarmActive}, 16'h0000);
    wr16(ALARM_ONE_THRESHOLD_ADDR, 16'h8064);
    strobe(14'd200);
    check({14'h0, alarmActive}, 16'h0001);
    check({14'h0, lineOe[1], lineOut[1]}, 16'h0003);
    wrb(GLOBAL_COMMAND_ADDR, 8'h10);
    settle();
    check({14'h0, alarmActive[0], lineOut[1]}, 16'h0000);
    wrb(ALARM_SETUP_ADDR + 7'h01, 8'h00);
    strobe(14'd200);
    check({14'h0, alarmActive}, 16'h0000);
    wr16(ALARM_TWO_THRESHOLD_ADDR, 16'h8064);
    wrb(ALARM_SETUP_ADDR + 7'h01, 8'h60);
    rawData[6] <= 14'd200;
    filtData[6] <= 14'd50;
    strobe(14'd0);
    check({14'h0, alarmActive}, 16'h0000);
    @(posedge ref_clk);
    filtData[6] <= 14'd150;
    strobe(14'd0);
    check({14'h0, alarmActive}, 16'h0002);
    do_reset();
    wr16(ALARM_ONE_SAMPLE_COUNT_ADDR, 16'h0002);
    wr16(ALARM_ONE_THRESHOLD_ADDR, 16'h800a);
    wr16(ALARM_SETUP_ADDR, 16'h0220);
    strobe(14'd0);
    strobe(14'd30);
    check({14'h0, alarmActive}, 16'h0000);
    strobe(14'd60);
    check({14'h0, alarmActive}, 16'h0001);
    wr16(X_ACCEL_OFFSET_NULL_ADDR, 16'h1234);
    wrb(AUX_CONVERTER_LEVEL_ADDR, 8'h55);
    wrb(GLOBAL_COMMAND_ADDR, 8'h08);
    settle();
    check({15'h0, flashBusy}, 16'h0001);
    wrb(X_ACCEL_OFFSET_NULL_ADDR, 8'h00);
    wait_idle();
    rd(X_ACCEL_OFFSET_NULL_ADDR, 16'h1234);
    wrb(GLOBAL_COMMAND_ADDR, 8'h02);
    settle();
    rd(X_ACCEL_OFFSET_NULL_ADDR, 16'h0000);
    wrb(GLOBAL_COMMAND_ADDR, 8'h80);
    settle();
    rd(X_ACCEL_OFFSET_NULL_ADDR, 16'h1234);
    rd(AUX_CONVERTER_LEVEL_ADDR, 16'h0000);
    @(posedge ref_clk);
    failMode <= 1'b1;
    wrb(GLOBAL_COMMAND_ADDR, 8'h08);
    settle();
    wait_idle();
    check({15'h0, flashError}, 16'h0001);
    wrb(GLOBAL_COMMAND_ADDR, 8'h08);
    settle();
    check({15'h0, flashBusy}, 16'h0000);
    @(posedge ref_clk);
    statusRead <= 1'b1;
    failMode <= 1'b0;
    @(posedge ref_clk);
    statusRead <= 1'b0;
    settle();
    check({15'h0, flashError}, 16'h0000);
    @(posedge ref_clk);
    resultData[0] <= 14'h0005;
    resultData[4] <= 14'h3ffd;
    wrb(GLOBAL_COMMAND_ADDR, 8'h01);
    settle();
    check({15'h0, flashBusy}, 16'h0001);
    wait_idle();
    rd(X_ACCEL_OFFSET_NULL_ADDR, 16'h3ffb);
    rd(ROTATION_OFFSET_NULL_ADDR, 16'h0003);
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end
endmodule : aio_regs_tb_top
